// ==== shared/dias_pkg.sv ====
// constants and types for the dual bus register access slave
package dias_pkg;
    localparam logic [7:0] DEV_WR_BYTE    = 8'h68;
    localparam logic [7:0] DEV_RD_BYTE    = 8'h69;
    localparam logic [7:0] REG_TOP        = 8'hbf;
    localparam logic [7:0] WR_TOP         = 8'haf;
    localparam logic [7:0] REG_RST        = 8'h00;
    localparam logic [7:0] PTR_RST        = 8'h00;
    localparam int         CLK_FREQ_KHZ   = 125000;
    localparam int         CONFLICT_NS    = 110;
    localparam int         CONFLICT_CYC   =
        (CONFLICT_NS * CLK_FREQ_KHZ + 999999) / 1000000;
    localparam int         TIMEOUT_MS     = 30;
    localparam int         TIMEOUT_CYC    = TIMEOUT_MS * CLK_FREQ_KHZ;
    localparam int         RECOVER_PULSES = 10;
    localparam int         AGE_W          = 5;
    localparam int         TO_W           = 22;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV  = 3'b001,
        ST_REG  = 3'b010,
        ST_DATA = 3'b011,
        ST_RD   = 3'b100,
        ST_RACK = 3'b101
    } dias_state_e;
endpackage : dias_pkg

// ==== hw/dias_top.sv ====
// two bus slave engines sharing one register ram
`timescale 1ns/1ps
// Behaviour
// - read: write address, register byte, repeated start, read address, data
// - single-byte write may end with a start instead of stop
// - power engine never answers reads; only the standard engine reads
// - own address acked; allowed register byte loads pointer, else nacked
// - data byte committed at the end of the device ack bit
// - stop or start before ack clock falls abandons the write
// - read starts from the register held in the pointer
// - stop returns to idle; idle ignores everything until a start
// - repeated start acts exactly as a start, interrupting anything
// - any other slave address after start is not acknowledged
// - reserved register byte nacked and pointer left unchanged
// - read-only target: register byte acked, data acked and discarded
// - read pointer increments per acked byte, wraps to zero and stops
// - power bus takes repeated register/data pairs until stop
// - each engine keeps its own pointer; distinct registers never interact
// - read before power write gets old value, after gets new
// - writes apart keep the later; close writes keep the power value
// - clock lines are never held low; conflicts resolved internally
// - ack 0x68 for write and 0x69 for read only
// - data low 30ms resets engine; clock low 30ms flags timeout
// - stuck data line released after 10 host clock pulses
// - engines held in reset during sequencer power-up and sleep

module dias_engine #(
    parameter bit          STD    = 1'b1,
    parameter int unsigned TO_CYC = dias_pkg::TIMEOUT_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       hold,
    input  wire logic       scl_pin,
    input  wire logic       sda_pin,
    input  wire logic [7:0] rd_data,
    output logic            sda_oe_n,
    output logic            scl_timeout,
    output logic [7:0]      ptr,
    output logic            wr_stb,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data
);
    import dias_pkg::*;

    localparam logic [TO_W-1:0] TO_MAX = TO_W'(TO_CYC);
    localparam logic [3:0]      REC_LAST = 4'(RECOVER_PULSES - 1);

    logic              scl_m, scl_s, scl_q;
    logic              sda_m, sda_s, sda_q;
    logic [TO_W-1:0]   scl_lo, sda_lo;
    logic              eng_rst;
    logic              scl_rise, scl_fall, start, stop;
    dias_state_e       state;
    logic [3:0]        cnt;
    logic [7:0]        sh;
    logic              in_ack;
    logic [3:0]        rec;
    logic              rec_done;
    logic              ack;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            {scl_m, scl_s, scl_q} <= 3'h7;
            {sda_m, sda_s, sda_q} <= 3'h7;
        end else begin
            scl_m <= scl_pin;
            scl_s <= scl_m;
            scl_q <= scl_s;
            sda_m <= sda_pin;
            sda_s <= sda_m;
            sda_q <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start    = scl_s & scl_q & sda_q & ~sda_s;
    assign stop     = scl_s & scl_q & ~sda_q & sda_s;

    // low-level watchdogs on both lines
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scl_lo      <= '0;
            sda_lo      <= '0;
            scl_timeout <= 1'b0;
        end else begin
            scl_lo      <= scl_s ? '0 : (scl_lo == TO_MAX ? scl_lo
                                                          : scl_lo + 1'b1);
            sda_lo      <= sda_s ? '0 : (sda_lo == TO_MAX ? sda_lo
                                                          : sda_lo + 1'b1);
            scl_timeout <= (scl_lo == TO_MAX);
        end
    end

    assign eng_rst = !rst_n || hold || (sda_lo == TO_MAX);

    // counts host clocks while this engine pulls the data line
    always_ff @(posedge ref_clk) begin
        if (eng_rst || sda_oe_n) begin
            rec <= 4'h0;
        end else if (scl_rise) begin
            rec <= rec + 4'h1;
        end
    end
    assign rec_done = !sda_oe_n && scl_rise && (rec == REC_LAST);

    always_comb begin
        unique case (state)
            ST_DEV:  ack = (sh == DEV_WR_BYTE) ||
                           (STD && sh == DEV_RD_BYTE);
            ST_REG:  ack = (sh <= REG_TOP);
            ST_DATA: ack = 1'b1;
            default: ack = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (eng_rst) begin
            state    <= ST_IDLE;
            cnt      <= 4'h0;
            sh       <= 8'h00;
            in_ack   <= 1'b0;
            sda_oe_n <= 1'b1;
            ptr      <= PTR_RST;
            wr_stb   <= 1'b0;
            wr_addr  <= 8'h00;
            wr_data  <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (start) begin
                state    <= ST_DEV;
                cnt      <= 4'h0;
                in_ack   <= 1'b0;
                sda_oe_n <= 1'b1;
            end else if (stop) begin
                state    <= ST_IDLE;
                in_ack   <= 1'b0;
                sda_oe_n <= 1'b1;
            end else if (rec_done) begin
                state    <= ST_IDLE;
                in_ack   <= 1'b0;
                sda_oe_n <= 1'b1;
            end else if (state != ST_IDLE && scl_rise) begin
                if (state == ST_RACK) begin
                    if (sda_s) begin
                        state <= ST_IDLE;
                    end else if (ptr == REG_TOP) begin
                        ptr   <= 8'h00;
                        state <= ST_IDLE;
                    end else begin
                        ptr   <= ptr + 8'h01;
                        state <= ST_RD;
                        cnt   <= 4'h8;
                    end
                end else if (state != ST_RD && !in_ack) begin
                    sh  <= {sh[6:0], sda_s};
                    cnt <= cnt + 4'h1;
                end
            end else if (state != ST_IDLE && scl_fall) begin
                if (in_ack) begin
                    in_ack   <= 1'b0;
                    sda_oe_n <= 1'b1;
                    unique case (state)
                        ST_DEV: begin
                            if (sh[0]) begin
                                state    <= ST_RD;
                                sh       <= rd_data;
                                sda_oe_n <= rd_data[7];
                                cnt      <= 4'h0;
                            end else begin
                                state <= ST_REG;
                            end
                        end
                        ST_REG: state <= ST_DATA;
                        ST_DATA: begin
                            wr_stb  <= (ptr <= WR_TOP);
                            wr_addr <= ptr;
                            wr_data <= sh;
                            state   <= STD ? ST_IDLE : ST_REG;
                        end
                        default: state <= ST_IDLE;
                    endcase
                end else if (state == ST_RD) begin
                    if (cnt == 4'h8) begin
                        sh       <= rd_data;
                        sda_oe_n <= rd_data[7];
                        cnt      <= 4'h0;
                    end else if (cnt == 4'h7) begin
                        sda_oe_n <= 1'b1;
                        state    <= ST_RACK;
                    end else begin
                        sda_oe_n <= sh[6];
                        sh       <= {sh[6:0], 1'b0};
                        cnt      <= cnt + 4'h1;
                    end
                end else if (cnt == 4'h8) begin
                    cnt      <= 4'h0;
                    in_ack   <= ack;
                    sda_oe_n <= ~ack;
                    if (state == ST_REG && ack) begin
                        ptr <= sh;
                    end
                    if (!ack) begin
                        state <= ST_IDLE;
                    end
                end
            end
        end
    end
endmodule : dias_engine

module dias_top #(
    parameter int unsigned TIMEOUT_CYCLES = dias_pkg::TIMEOUT_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic seq_power_up,
    input  wire logic seq_sleep,
    input  wire logic std_bus_clock_line,
    input  wire logic std_bus_data_line_in,
    output logic      std_bus_data_line_out,
    output logic      std_bus_data_line_oe_n,
    input  wire logic power_bus_clock_line,
    input  wire logic power_bus_data_line_in,
    output logic      power_bus_data_line_out,
    output logic      power_bus_data_line_oe_n,
    output logic      std_clock_timeout,
    output logic      power_clock_timeout
);
    import dias_pkg::*;

    localparam logic [AGE_W-1:0] CC = AGE_W'(CONFLICT_CYC);

    logic [7:0]       ram [256];
    logic [7:0]       std_ptr, std_addr, std_data, pw_addr, pw_data;
    logic             std_stb, pw_stb, hold;
    logic             pend, std_commit, pw_hit_pend;
    logic [7:0]       pend_addr, pend_data, pw_last;
    logic [AGE_W-1:0] pend_cnt, pw_age;

    assign hold = seq_power_up || seq_sleep;

    // the clock lines are inputs only, so no transfer is ever stretched
    dias_engine #(.STD(1'b1), .TO_CYC(TIMEOUT_CYCLES)) u_std (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .hold        (hold),
        .scl_pin     (std_bus_clock_line),
        .sda_pin     (std_bus_data_line_in),
        .rd_data     (ram[std_ptr]),
        .sda_oe_n    (std_bus_data_line_oe_n),
        .scl_timeout (std_clock_timeout),
        .ptr         (std_ptr),
        .wr_stb      (std_stb),
        .wr_addr     (std_addr),
        .wr_data     (std_data)
    );

    dias_engine #(.STD(1'b0), .TO_CYC(TIMEOUT_CYCLES)) u_pwr (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .hold        (hold),
        .scl_pin     (power_bus_clock_line),
        .sda_pin     (power_bus_data_line_in),
        .rd_data     (8'h00),
        .sda_oe_n    (power_bus_data_line_oe_n),
        .scl_timeout (power_clock_timeout),
        .ptr         (),
        .wr_stb      (pw_stb),
        .wr_addr     (pw_addr),
        .wr_data     (pw_data)
    );

    // the pins only ever pull low
    always_ff @(posedge ref_clk) begin
        std_bus_data_line_out   <= 1'b0;
        power_bus_data_line_out <= 1'b0;
    end

    // standard writes wait out the conflict window; a power write to the
    // same register inside that window, before or after, drops them
    assign pw_hit_pend = pw_stb && (pw_addr == pend_addr);
    assign std_commit  = pend && (pend_cnt == '0) && !pw_hit_pend;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pend      <= 1'b0;
            pend_cnt  <= '0;
            pend_addr <= 8'h00;
            pend_data <= 8'h00;
            pw_age    <= CC;
            pw_last   <= 8'h00;
        end else begin
            pw_age <= pw_stb ? '0 : (pw_age == CC ? pw_age
                                                   : pw_age + 1'b1);
            if (pw_stb) begin
                pw_last <= pw_addr;
            end
            if (std_stb) begin
                pend      <= !((pw_age < CC) && (pw_last == std_addr)) &&
                             !(pw_stb && (pw_addr == std_addr));
                pend_cnt  <= CC - 1'b1;
                pend_addr <= std_addr;
                pend_data <= std_data;
            end else if (pend) begin
                if (pw_hit_pend || pend_cnt == '0) begin
                    pend <= 1'b0;
                end else begin
                    pend_cnt <= pend_cnt - 1'b1;
                end
            end
        end
    end

    // power write is applied last so it wins any same-cycle collision
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 256; i++) begin
                ram[i] <= REG_RST;
            end
        end else begin
            if (std_commit) begin
                ram[pend_addr] <= pend_data;
            end
            if (pw_stb) begin
                ram[pw_addr] <= pw_data;
            end
        end
    end
endmodule : dias_top

// ==== tb/dias_checker.sv ====
// port checker for the dual bus register access slave
`timescale 1ns/1ps
module dias_checker #(
    parameter int unsigned TIMEOUT_CYCLES = 200
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic seq_power_up,
    input wire logic seq_sleep,
    input wire logic std_bus_clock_line,
    input wire logic std_bus_data_line_in,
    input wire logic std_bus_data_line_out,
    input wire logic std_bus_data_line_oe_n,
    input wire logic power_bus_clock_line,
    input wire logic power_bus_data_line_in,
    input wire logic power_bus_data_line_out,
    input wire logic power_bus_data_line_oe_n,
    input wire logic std_clock_timeout,
    input wire logic power_clock_timeout
);
    logic [31:0] low_cnt;
    logic [3:0]  rise_cnt;
    logic        scl_q;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // scl low time at the pin, saturating just past the timeout
    always_ff @(posedge ref_clk) begin
        if (std_bus_clock_line)
            low_cnt <= '0;
        else if (low_cnt < TIMEOUT_CYCLES + 9)
            low_cnt <= low_cnt + 32'd1;
    end
    // scl rises seen while the device keeps pulling sda
    always_ff @(posedge ref_clk) begin
        scl_q <= std_bus_clock_line;
        if (std_bus_data_line_oe_n)
            rise_cnt <= '0;
        else if (std_bus_clock_line && !scl_q)
            rise_cnt <= rise_cnt + 4'd1;
    end
    sequence s_ack_hold;
        !power_bus_data_line_oe_n [*8];
    endsequence
    property p_out_low;
        !std_bus_data_line_out && !power_bus_data_line_out;
    endproperty
    a_out_low: assert property (p_out_low)
        else $error("data output not low");
    property p_drive;
        $fell(std_bus_data_line_oe_n) |-> !std_bus_clock_line;
    endproperty
    a_drive: assert property (p_drive)
        else $error("sda pulled while scl high");
    property p_free;
        $rose(std_bus_data_line_oe_n) && rise_cnt != 4'd10
            && !$past(seq_power_up) && !$past(seq_sleep)
            |-> !std_bus_clock_line;
    endproperty
    a_free: assert property (p_free)
        else $error("sda released while scl high");
    property p_pwr_ack;
        $fell(power_bus_data_line_oe_n) |-> s_ack_hold;
    endproperty
    a_pwr_ack: assert property (p_pwr_ack)
        else $error("power bus pull shorter than a bit");
    property p_to_set;
        low_cnt == TIMEOUT_CYCLES + 8 |-> std_clock_timeout;
    endproperty
    a_to_set: assert property (p_to_set)
        else $error("clock timeout missing");
    property p_to_early;
        $rose(std_clock_timeout) |-> low_cnt >= TIMEOUT_CYCLES;
    endproperty
    a_to_early: assert property (p_to_early)
        else $error("clock timeout too early");
    property p_to_clr;
        $rose(std_bus_clock_line) |-> ##[1:8] !std_clock_timeout;
    endproperty
    a_to_clr: assert property (p_to_clr)
        else $error("clock timeout not cleared");
    property p_seq;
        seq_power_up || seq_sleep
            |=> std_bus_data_line_oe_n && power_bus_data_line_oe_n;
    endproperty
    a_seq: assert property (p_seq)
        else $error("engine not held in reset");
    property p_recover;
        rise_cnt <= 4'd10;
    endproperty
    a_recover: assert property (p_recover)
        else $error("sda held past ten clocks");
endmodule : dias_checker

bind dias_top dias_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .seq_power_up(seq_power_up),
    .seq_sleep(seq_sleep), .std_bus_clock_line(std_bus_clock_line),
    .std_bus_data_line_in(std_bus_data_line_in),
    .std_bus_data_line_out(std_bus_data_line_out),
    .std_bus_data_line_oe_n(std_bus_data_line_oe_n),
    .power_bus_clock_line(power_bus_clock_line),
    .power_bus_data_line_in(power_bus_data_line_in),
    .power_bus_data_line_out(power_bus_data_line_out),
    .power_bus_data_line_oe_n(power_bus_data_line_oe_n),
    .std_clock_timeout(std_clock_timeout),
    .power_clock_timeout(power_clock_timeout));

// ==== tb/dias_host.sv ====
// host bus master model for one two-wire bus
`timescale 1ns/1ps
module dias_host (
    output logic     scl,
    output logic     lo,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        lo = 1'b0;
    end
    // 80 ns bit: sda moves 16 ns into the low phase, the rise comes 16 ns
    // later so a device pull launched about 20 ns after the fall is settled
    task automatic bit_x(input logic b, output logic r);
        lo = ~b;
        #16 scl = 1'b1;
        #48 r = sda;
        scl = 1'b0;
        #16;
    endtask : bit_x
    task automatic start();
        lo = 1'b0;
        #40 scl = 1'b1;
        #40 lo = 1'b1;
        #40 scl = 1'b0;
        #40;
    endtask : start
    task automatic stop();
        lo = 1'b1;
        #40 scl = 1'b1;
        #40 lo = 1'b0;
        #40;
    endtask : stop
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(v[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic hack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, v[i]);
        bit_x(~hack, r);
    endtask : rbyte
    task automatic park(input logic v);
        scl = v;
    endtask : park
    // holds the data line low (1) or lets it go (0) with no clocking
    task automatic pull(input logic v);
        lo = v;
    endtask : pull
endmodule : dias_host

// ==== tb/dias_top_tb.sv ====
// self-checking bench for the dual bus register access slave
`timescale 1ns/1ps
module dias_top_tb;
    import dias_pkg::*;
    localparam int unsigned TO_CYC = 200;
    logic       ref_clk, rst_n, seq_power_up, seq_sleep;
    logic       s_scl, s_lo, s_oe_n, s_to, p_scl, p_lo, p_oe_n, p_to;
    logic [7:0] d;
    int         miscompares;
    int         cmp_count;
    wire        s_sda = ~s_lo & s_oe_n;
    wire        p_sda = ~p_lo & p_oe_n;
    dias_top #(.TIMEOUT_CYCLES(TO_CYC)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .seq_power_up(seq_power_up),
        .seq_sleep(seq_sleep), .std_bus_clock_line(s_scl),
        .std_bus_data_line_in(s_sda), .std_bus_data_line_out(),
        .std_bus_data_line_oe_n(s_oe_n), .power_bus_clock_line(p_scl),
        .power_bus_data_line_in(p_sda), .power_bus_data_line_out(),
        .power_bus_data_line_oe_n(p_oe_n), .std_clock_timeout(s_to),
        .power_clock_timeout(p_to));
    dias_host hs (.scl(s_scl), .lo(s_lo), .sda(s_sda));
    dias_host hp (.scl(p_scl), .lo(p_lo), .sda(p_sda));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic st(input bit pw);
        if (pw)
            hp.start();
        else
            hs.start();
    endtask : st
    task automatic sp(input bit pw);
        if (pw)
            hp.stop();
        else
            hs.stop();
    endtask : sp
    task automatic op(input bit pw, input logic [7:0] v, input logic ex);
        logic k;
        if (pw)
            hp.wbyte(v, k);
        else
            hs.wbyte(v, k);
        chk({7'h00, k}, {7'h00, ex});
    endtask : op
    task automatic sw(input bit pw, input logic [7:0] r, v, input bit fin);
        st(pw);
        op(pw, DEV_WR_BYTE, 1'b1);
        op(pw, r, 1'b1);
        op(pw, v, 1'b1);
        if (fin)
            sp(pw);
    endtask : sw
    task automatic ptr(input logic [7:0] r, input logic ex);
        hs.start();
        op(1'b0, DEV_WR_BYTE, 1'b1);
        op(1'b0, r, ex);
        hs.stop();
    endtask : ptr
    // one byte at the current pointer, ended by nack and stop
    task automatic rd(input logic [7:0] ex);
        hs.start();
        op(1'b0, DEV_RD_BYTE, 1'b1);
        hs.rbyte(1'b0, d);
        chk(d, ex);
        hs.stop();
    endtask : rd
    task automatic reg_is(input logic [7:0] r, ex);
        ptr(r, 1'b1);
        rd(ex);
    endtask : reg_is
    task automatic t_addr();
        logic [7:0] bad [3] = '{8'h6a, 8'h00, 8'hd0};
        for (int b = 0; b < 2; b++) begin
            foreach (bad[i]) begin
                st(b[0]);
                op(b[0], bad[i], 1'b0);
                sp(b[0]);
            end
        end
        hp.start();
        op(1'b1, DEV_RD_BYTE, 1'b0);
        hp.stop();
    endtask : t_addr
    task automatic t_rw();
        sw(1'b0, 8'h10, 8'ha5, 1'b0);
        sw(1'b0, 8'h11, 8'h3c, 1'b1);
        hs.start();
        op(1'b0, DEV_WR_BYTE, 1'b1);
        op(1'b0, 8'h10, 1'b1);
        hs.start();
        op(1'b0, DEV_RD_BYTE, 1'b1);
        hs.rbyte(1'b1, d);
        chk(d, 8'ha5);
        hs.rbyte(1'b0, d);
        chk(d, 8'h3c);
        hs.stop();
    endtask : t_rw
    task automatic t_bad();
        ptr(8'h11, 1'b1);
        ptr(8'hc0, 1'b0);
        rd(8'h3c);
        sw(1'b0, WR_TOP + 8'h01, 8'h77, 1'b1);
        rd(8'h00);
        sw(1'b0, 8'h00, 8'h5a, 1'b1);
        ptr(REG_TOP, 1'b1);
        hs.start();
        op(1'b0, DEV_RD_BYTE, 1'b1);
        hs.rbyte(1'b1, d);
        chk(d, 8'h00);
        hs.stop();
        rd(8'h5a);
    endtask : t_bad
    task automatic t_abort();
        for (int e = 0; e < 2; e++) begin
            hs.start();
            op(1'b0, DEV_WR_BYTE, 1'b1);
            op(1'b0, 8'h20, 1'b1);
            repeat (7) hs.bit_x(1'b1, d[0]);
            if (e == 1)
                hs.start();
            hs.stop();
            reg_is(8'h20, 8'h00);
        end
    endtask : t_abort
    task automatic t_power();
        ptr(8'h10, 1'b1);
        hp.start();
        op(1'b1, DEV_WR_BYTE, 1'b1);
        for (int i = 0; i < 2; i++) begin
            op(1'b1, 8'h30 + 8'(i), 1'b1);
            op(1'b1, 8'h11 * 8'(i + 1), 1'b1);
        end
        hp.stop();
        rd(8'ha5);
        reg_is(8'h30, 8'h11);
        reg_is(8'h31, 8'h22);
        sw(1'b0, 8'h30, 8'h44, 1'b1);
        reg_is(8'h30, 8'h44);
        fork
            sw(1'b0, 8'h40, 8'h01, 1'b1);
            sw(1'b1, 8'h40, 8'h02, 1'b1);
        join
        reg_is(8'h40, 8'h02);
    endtask : t_power
    task automatic t_seq();
        for (int i = 0; i < 2; i++) begin
            hs.start();
            op(1'b0, DEV_WR_BYTE, 1'b1);
            op(1'b0, 8'h50, 1'b1);
            seq_power_up = (i == 0);
            seq_sleep = (i == 1);
            repeat (3) @(negedge ref_clk);
            seq_power_up = 1'b0;
            seq_sleep = 1'b0;
            op(1'b0, 8'h66, 1'b0);
            hs.stop();
        end
        reg_is(8'h50, 8'h00);
        // data line held low past the timeout resets the pointer to zero
        hs.start();
        op(1'b0, DEV_WR_BYTE, 1'b1);
        op(1'b0, 8'h20, 1'b1);
        hs.pull(1'b1);
        repeat (TO_CYC + 20) @(negedge ref_clk);
        hs.pull(1'b0);
        hs.stop();
        rd(8'h5a);
        hs.park(1'b0);
        hp.park(1'b0);
        repeat (TO_CYC + 20) @(negedge ref_clk);
        chk({6'h00, s_to, p_to}, 8'h03);
        hs.park(1'b1);
        hp.park(1'b1);
        repeat (10) @(negedge ref_clk);
        chk({6'h00, s_to, p_to}, 8'h00);
        reg_is(8'h10, 8'ha5);
    endtask : t_seq
    initial begin
        rst_n = 1'b0;
        seq_power_up = 1'b0;
        seq_sleep = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        t_addr();
        t_rw();
        t_bad();
        t_abort();
        t_power();
        t_seq();
        finish_test();
    end
    initial begin
        #600000;
        miscompares++;
        finish_test();
    end
endmodule : dias_top_tb
